// ### src/gyro_spi_defines.svh
/*
 * Shared constants for the angular rate sensor register bank and its SPI host:
 * register addresses, field positions, fixed field patterns, command byte layout
 * and host control register offsets.
 * Assumes inclusion by bare name from both design ends.
 */
`ifndef GYRO_SPI_DEFINES_SVH
`define GYRO_SPI_DEFINES_SVH

// ----------------------------------------------------------------------------
// Device register addresses
// ----------------------------------------------------------------------------
`define ADDR_COMMAND      6'h00
`define ADDR_IO_CONTROL   6'h01
`define ADDR_RATE_OUT     6'h08
`define ADDR_TEMP_OUT     6'h0A
`define ADDR_RATE_SETUP   6'h28
`define ADDR_TEMP_SETUP   6'h2A
`define ADDR_RATE_CONV    6'h30
`define ADDR_TEMP_CONV    6'h32
`define ADDR_RESOLUTION   6'h38

// ----------------------------------------------------------------------------
// Field positions and fixed patterns
// ----------------------------------------------------------------------------
`define CMD_FIXED_BIT     7
`define CMD_READ_BIT      6
`define IOC_ALL_BIT       3
`define IOC_SYNC_BIT      0
`define SETUP_EN_BIT      3
`define RES_24_BIT        1
`define IOC_FIXED         8'h30
`define SETUP_FIXED       8'h02
`define CONV_FIXED        8'h05
`define RES_FIXED         8'h20
`define RESET_BYTE        8'h00

// ----------------------------------------------------------------------------
// Host control register offsets and layout
// ----------------------------------------------------------------------------
`define HREG_CTRL         4'h0
`define HREG_STATUS       4'h1
`define HREG_IRQ_STAT     4'h2
`define HREG_IRQ_MASK     4'h3
`define HREG_DATA         4'h4
`define HCTRL_START_BIT   14
`define HCTRL_LEN_LSB     8
`define IRQ_DONE_BIT      0
`define IRQ_RDY_BIT       1
// A serial half period lasts SCLK_HALF_DIV + 1 clk cycles. The round trip from
// a falling serial edge, through the device synchronisers and back through the
// host synchronisers, takes six cycles, so shorter halves read stale data.
`define SCLK_HALF_DIV     8'h07

`endif

// ### src/gyro_spi_device.sv
/*
 * Register bank of the angular rate sensor behind a byte oriented SPI slave
 * (mode 3: data changes on falling, sampled on rising serial clock edges).
 * Assumes samples arrive from the converter on one-cycle strobes and that the
 * host holds each serial clock half for at least six clk cycles.
 */
`timescale 1ns/100ps
`default_nettype none
`include "gyro_spi_defines.svh"

// Summary of operation
// - First byte: command, read bit, address
// - Rate at 0x08, temperature at 0x0A
// - Ready mode all: low when all enabled fresh
// - Ready mode any: low when one enabled fresh
// - I/O control bit 0 enables sync
// - Host writes fixed I/O control patterns
// - Rate setup bit 3 enables channel
// - Temperature setup bit 3 enables channel
// - Host writes 0x05 conversion times
// - Resolution bit 1 picks 24 bits
// - Data MSB first, three or two bytes
// - Reading output register raises ready
// - Sync low holds conversions when enabled
// - Byte segments: command then data bytes
module gyro_spi_device
	import gyro_spi_pkg::*;
#(
	parameter int DATA_W = 24
) (
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              rstn,
	// Serial link.
	gyro_spi_if.device             spi,
	// Converter side.
	input  wire logic              rate_valid,
	input  wire logic [DATA_W-1:0] rate_sample,
	input  wire logic              temp_valid,
	input  wire logic [DATA_W-1:0] temp_sample,
	output logic                   conv_run,
	output logic                   rate_enable,
	output logic                   temp_enable,
	output logic                   res_24
);
	// ------------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------------
	logic [1:0] sclk_sync_reg;   // Serial clock synchroniser.
	logic [1:0] cs_sync_reg;     // Chip select synchroniser.
	logic [1:0] sdi_sync_reg;    // Data in synchroniser.
	logic [1:0] sync_sync_reg;   // Sync pin synchroniser.
	logic       sclk_old_reg;    // Previous synchronised serial clock.

	// Pins pass two flops before any logic reads them.
	always_ff @(posedge clk) begin
		sclk_sync_reg <= {sclk_sync_reg[0], spi.sclk};
		cs_sync_reg   <= {cs_sync_reg[0], spi.cs_n};
		sdi_sync_reg  <= {sdi_sync_reg[0], spi.sdi};
		sync_sync_reg <= {sync_sync_reg[0], spi.sync_n};
		sclk_old_reg  <= sclk_sync_reg[1];
	end

	wire sclk_rise = sclk_sync_reg[1] & ~sclk_old_reg;   // Sample edge.
	wire sclk_fall = ~sclk_sync_reg[1] & sclk_old_reg;   // Shift edge.
	wire selected  = ~cs_sync_reg[1];                    // Transfer active.

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	logic [7:0]        io_control_reg;    // I/O control.
	logic [7:0]        rate_setup_reg;    // Rate channel setup.
	logic [7:0]        temp_setup_reg;    // Temperature channel setup.
	logic [7:0]        rate_conv_reg;     // Rate conversion time.
	logic [7:0]        temp_conv_reg;     // Temperature conversion time.
	logic [7:0]        resolution_reg;    // Resolution control.
	logic [DATA_W-1:0] rate_out_reg;      // Rate output sample.
	logic [DATA_W-1:0] temp_out_reg;      // Temperature output sample.
	logic              rate_fresh_reg;    // Unread rate data.
	logic              temp_fresh_reg;    // Unread temperature data.

	// ------------------------------------------------------------------------
	// Serial shifter
	// ------------------------------------------------------------------------
	logic [7:0]        shift_in_reg;      // Incoming byte.
	logic [2:0]        bit_cnt_reg;       // Bits of the current byte.
	byte_cnt_t         byte_cnt_reg;      // Bytes completed this transfer.
	logic [7:0]        cmd_reg;           // Command byte held.
	logic [DATA_W-1:0] shift_out_reg;     // Outgoing read data.
	logic              sdo_reg;           // Data output flop.

	wire [7:0] byte_in   = {shift_in_reg[6:0], sdi_sync_reg[1]};
	wire       byte_done = sclk_rise & (bit_cnt_reg == 3'h7);
	wire [5:0] cmd_addr  = byte_in[5:0];
	wire       cmd_read  = byte_in[`CMD_READ_BIT] & ~byte_in[`CMD_FIXED_BIT];
	wire       cmd_byte  = byte_done & (byte_cnt_reg == 3'h0);
	wire       wr_byte   = byte_done & (byte_cnt_reg == 3'h1) & ~cmd_reg[`CMD_READ_BIT];
	wire [5:0] wr_addr   = cmd_reg[5:0];

	// Read data aligned so the first byte is in the top bits.
	function automatic logic [DATA_W-1:0] read_word(input logic [5:0] a);
		unique case (a)
			`ADDR_IO_CONTROL: read_word = {io_control_reg, 16'h0000};
			`ADDR_RATE_SETUP: read_word = {rate_setup_reg, 16'h0000};
			`ADDR_TEMP_SETUP: read_word = {temp_setup_reg, 16'h0000};
			`ADDR_RATE_CONV:  read_word = {rate_conv_reg, 16'h0000};
			`ADDR_TEMP_CONV:  read_word = {temp_conv_reg, 16'h0000};
			`ADDR_RESOLUTION: read_word = {resolution_reg, 16'h0000};
			// 16-bit mode sends the upper two bytes
			`ADDR_RATE_OUT:   read_word = rate_out_reg;
			`ADDR_TEMP_OUT:   read_word = temp_out_reg;
			default:          read_word = '0;
		endcase
	endfunction

	// Bit and byte counting, and command capture.
	always_ff @(posedge clk) begin
		if (!rstn || !selected) begin
			bit_cnt_reg  <= 3'h0;
			byte_cnt_reg <= 3'h0;
		end else if (sclk_rise) begin
			bit_cnt_reg  <= bit_cnt_reg + 3'h1;
			shift_in_reg <= byte_in;
			if (byte_done && byte_cnt_reg != 3'h7) begin
				byte_cnt_reg <= byte_cnt_reg + 3'h1;
			end
		end
		if (!rstn) begin
			cmd_reg <= `RESET_BYTE;
		end else if (cmd_byte) begin
			cmd_reg <= {byte_in[7:6], cmd_addr};
		end
	end

	// Output shifter: loads on a read command, shifts on falling edges.
	always_ff @(posedge clk) begin
		if (!rstn || !selected) begin
			shift_out_reg <= '0;
			sdo_reg       <= 1'b0;
		end else if (cmd_byte && cmd_read) begin
			shift_out_reg <= read_word(cmd_addr);
		end else if (sclk_fall && byte_cnt_reg != 3'h0) begin
			sdo_reg       <= shift_out_reg[DATA_W-1];
			shift_out_reg <= {shift_out_reg[DATA_W-2:0], 1'b0};
		end
	end

	assign spi.sdo    = sdo_reg;
	assign spi.sdo_oe = selected & cmd_reg[`CMD_READ_BIT] & (byte_cnt_reg != 3'h0);

	// ------------------------------------------------------------------------
	// Configuration writes
	// ------------------------------------------------------------------------
	// Host is trusted to place the fixed patterns; all bits are stored.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			io_control_reg <= `IOC_FIXED;
			rate_setup_reg <= `SETUP_FIXED;
			temp_setup_reg <= `SETUP_FIXED;
			rate_conv_reg  <= `CONV_FIXED;
			temp_conv_reg  <= `CONV_FIXED;
			resolution_reg <= `RES_FIXED;
		end else if (wr_byte) begin
			unique case (wr_addr)
				`ADDR_IO_CONTROL: io_control_reg <= byte_in;
				`ADDR_RATE_SETUP: rate_setup_reg <= byte_in;
				`ADDR_TEMP_SETUP: temp_setup_reg <= byte_in;
				`ADDR_RATE_CONV:  rate_conv_reg  <= byte_in;
				`ADDR_TEMP_CONV:  temp_conv_reg  <= byte_in;
				`ADDR_RESOLUTION: resolution_reg <= byte_in;
				default:          ;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Samples, unread flags and data ready
	// ------------------------------------------------------------------------
	// rate channel enable
	assign rate_enable = rate_setup_reg[`SETUP_EN_BIT];
	assign temp_enable = temp_setup_reg[`SETUP_EN_BIT];
	assign res_24      = resolution_reg[`RES_24_BIT];
	assign conv_run    = ~(io_control_reg[`IOC_SYNC_BIT] & ~sync_sync_reg[1]);

	wire rd_rate = cmd_byte & cmd_read & (cmd_addr == `ADDR_RATE_OUT);
	wire rd_temp = cmd_byte & cmd_read & (cmd_addr == `ADDR_TEMP_OUT);
	wire rd_any  = rd_rate | rd_temp;
	wire take_r  = rate_valid & rate_enable & conv_run;
	wire take_t  = temp_valid & temp_enable & conv_run;

	// New sample wins over a read in the same cycle.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rate_out_reg   <= '0;
			temp_out_reg   <= '0;
			rate_fresh_reg <= 1'b0;
			temp_fresh_reg <= 1'b0;
		end else begin
			if (take_r) begin
				rate_out_reg <= rate_sample;
			end
			if (take_t) begin
				temp_out_reg <= temp_sample;
			end
			rate_fresh_reg <= take_r | (rate_fresh_reg & ~rd_any);
			temp_fresh_reg <= take_t | (temp_fresh_reg & ~rd_any);
		end
	end

	// Disabled channels count as satisfied in all mode, absent in any mode.
	wire all_fresh = (rate_fresh_reg | ~rate_enable) & (temp_fresh_reg | ~temp_enable)
		& (rate_enable | temp_enable);
	wire any_fresh = (rate_fresh_reg & rate_enable) | (temp_fresh_reg & temp_enable);
	assign spi.rdy_n = ~(io_control_reg[`IOC_ALL_BIT] ? all_fresh : any_fresh);
endmodule
`default_nettype wire

// ### src/gyro_spi_host.sv
/*
 * SPI host for the sensor register bank. Software loads a command through a
 * small register port; the host runs the transfer and reports through status.
 * Assumes a device in mode 3 that samples on rising serial clock edges.
 */
`timescale 1ns/100ps
`default_nettype none
`include "gyro_spi_defines.svh"
module gyro_spi_host
	import gyro_spi_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rstn,
	// Register port.
	input  wire logic [3:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	output logic             irq,
	// Serial link.
	gyro_spi_if.host         spi,
	// Sync pin level requested by the system.
	input  wire logic        sync_level
);
	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	host_state_t  state_reg;     // Sequencer state.
	logic [7:0]   div_reg;       // Half period divider.
	logic         sclk_reg;      // Serial clock out.
	logic [31:0]  shift_reg;     // Outgoing bits, MSB first.
	logic [23:0]  rx_reg;        // Received bits.
	logic [5:0]   bits_reg;      // Bits left, up to five whole bytes.
	logic [1:0]   irq_stat_reg;  // Sticky events.
	logic [1:0]   irq_mask_reg;  // Event mask.
	logic [1:0]   rdy_sync_reg;  // Data ready synchroniser.
	logic         rdy_old_reg;   // Previous ready level.
	logic [1:0]   sdo_sync_reg;  // Data in synchroniser.

	wire tick      = (div_reg == `SCLK_HALF_DIV);
	wire wr_ctrl   = wr & (addr == `HREG_CTRL) & wdata[`HCTRL_START_BIT];
	wire start     = wr_ctrl & (state_reg == H_IDLE);
	// command byte plus one to four bytes
	// Frame bytes are the extra count plus the command and one data byte.
	wire [5:0] nbits = {{1'b0, wdata[`HCTRL_LEN_LSB+1:`HCTRL_LEN_LSB]} + 3'h2, 3'h0};
	wire done_ev   = (state_reg == H_SHIFT) & tick & sclk_reg == 1'b0 & bits_reg == 6'h01;
	wire rdy_ev    = ~rdy_sync_reg[1] & rdy_old_reg;
	wire clr_wr    = wr & (addr == `HREG_IRQ_STAT);

	// Pin synchronisers.
	always_ff @(posedge clk) begin
		rdy_sync_reg <= {rdy_sync_reg[0], spi.rdy_n};
		sdo_sync_reg <= {sdo_sync_reg[0], spi.sdo};
		rdy_old_reg  <= rdy_sync_reg[1];
	end

	// Sequencer: low clock half shifts out, rising edge samples in.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			state_reg <= H_IDLE;
			div_reg   <= 8'h00;
			sclk_reg  <= 1'b1;
			bits_reg  <= 6'h00;
			shift_reg <= 32'h00000000;
			rx_reg    <= 24'h000000;
		end else begin
			div_reg <= (tick || state_reg == H_IDLE) ? 8'h00 : div_reg + 8'h01;
			unique case (state_reg)
				H_IDLE: if (start) begin
					// command byte in the top bits
					// A pad bit leads; the first falling edge pushes it out.
					shift_reg <= {1'b0, wdata[7:0], wdata[31:24], 15'h0000};
					bits_reg  <= nbits;
					state_reg <= H_SHIFT;
				end
				H_SHIFT: if (tick) begin
					sclk_reg <= ~sclk_reg;
					if (sclk_reg) begin
						// Falling edge: data out changes while the clock is low.
						shift_reg <= {shift_reg[30:0], 1'b0};
					end else begin
						// Rising edge: take the device bit, count it.
						rx_reg   <= {rx_reg[22:0], sdo_sync_reg[1]};
						bits_reg <= bits_reg - 6'h01;
						if (bits_reg == 6'h01) begin
							state_reg <= H_GAP;
						end
					end
				end
				H_GAP: if (tick) begin
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

	assign spi.sclk   = sclk_reg;
	assign spi.cs_n   = (state_reg == H_IDLE);
	assign spi.sdi    = shift_reg[31];
	assign spi.sync_n = sync_level;

	// Events, mask, and read port; a new event wins over a clear.
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq_stat_reg <= 2'b00;
			irq_mask_reg <= 2'b00;
			rdata        <= 32'h00000000;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~(clr_wr ? wdata[1:0] : 2'b00))
				| {rdy_ev, done_ev};
			if (wr && addr == `HREG_IRQ_MASK) begin
				irq_mask_reg <= wdata[1:0];
			end
			if (rd) begin
				unique case (addr)
					`HREG_STATUS:   rdata <= {30'h0, ~rdy_sync_reg[1], state_reg != H_IDLE};
					`HREG_IRQ_STAT: rdata <= {30'h0, irq_stat_reg};
					`HREG_IRQ_MASK: rdata <= {30'h0, irq_mask_reg};
					`HREG_DATA:     rdata <= {8'h00, rx_reg};
					default:        rdata <= 32'h00000000;
				endcase
			end
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule
`default_nettype wire

// ### src/gyro_spi_if.sv
/*
 * Four-wire SPI link between the sensor register bank and its host, plus the
 * data-ready and synchronisation pins.
 * Assumes the bench resolves the tri-state data output from its enable.
 */
`timescale 1ns/100ps
`default_nettype none
interface gyro_spi_if;
	logic sclk;        // Serial clock made by the host.
	logic cs_n;        // Chip select, active low.
	logic sdi;         // Host to device data.
	logic sdo;         // Device to host data.
	logic sdo_oe;      // Device drives the data output while high.
	logic rdy_n;       // Data ready, active low.
	logic sync_n;      // Conversion hold, active low.
	// ------------------------------------------------------------------------
	// Party views
	// ------------------------------------------------------------------------
	modport device (input sclk, input cs_n, input sdi, input sync_n,
		output sdo, output sdo_oe, output rdy_n);
	modport host (output sclk, output cs_n, output sdi, output sync_n,
		input sdo, input sdo_oe, input rdy_n);
endinterface
`default_nettype wire

// ### src/gyro_spi_pkg.sv
/*
 * Types shared by the two ends of the sensor SPI link.
 * Assumes the defines header is available on the include path.
 */
package gyro_spi_pkg;
	// Host transfer sequencer states.
	typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} host_state_t;
	// Byte counter type, counts up to seven bytes.
	typedef logic [2:0] byte_cnt_t;
endpackage

// ### verif/gyro_spi_properties.sv
/* Checker for the sensor SPI link, fed the interface wires as plain inputs.
   Assumes the bench places it once beside the interface joining both ends. */
`timescale 1ns/100ps
`default_nettype none
module gyro_spi_properties (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Link wires.
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe,
	input wire logic rdy_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic [5:0] bit_cnt_reg;  // Rising serial edges in this frame.
	logic [4:0] idle_cnt_reg; // Cycles since select was last low.
	logic       sclk_q_reg;   // Serial clock one cycle ago.
	// Counts bits per frame and the quiet time after it.
	always_ff @(posedge clk) begin
		sclk_q_reg <= sclk;
		if (!rstn || cs_n) begin
			bit_cnt_reg <= 6'h00;
		end else if (sclk && !sclk_q_reg) begin
			bit_cnt_reg <= bit_cnt_reg + 6'h01;
		end
		if (!rstn || !cs_n) begin
			idle_cnt_reg <= 5'h00;
		end else if (idle_cnt_reg != 5'h1F) begin
			idle_cnt_reg <= idle_cnt_reg + 5'h01;
		end
	end
	property p_idle_sclk; cs_n && $past(cs_n) |-> sclk; endproperty
	property p_start_high; $fell(cs_n) |-> sclk; endproperty
	// The device sees select through two flops, so it may drive two cycles late.
	property p_oe_sel; sdo_oe |-> !cs_n || !$past(cs_n) || !$past(cs_n, 2); endproperty
	property p_half; !cs_n && $changed(sclk) |=> $stable(sclk) [*3]; endproperty
	property p_sdi_hold; $rose(sclk) && !cs_n |-> $stable(sdi); endproperty
	property p_sdo_hold;
		sclk && $past(sclk) && sdo_oe && $past(sdo_oe) |-> $stable(sdo);
	endproperty
	property p_frame_len;
		$rose(cs_n) |-> bit_cnt_reg[2:0] == 3'h0 && bit_cnt_reg >= 6'h10 && bit_cnt_reg <= 6'h20;
	endproperty
	property p_rdy_rise; $rose(rdy_n) |-> idle_cnt_reg < 5'h10; endproperty
	a_idle_sclk: assert property (p_idle_sclk) else $error("clock moved while idle");
	a_start_high: assert property (p_start_high) else $error("frame began low");
	a_oe_sel: assert property (p_oe_sel) else $error("data driven unselected");
	a_half: assert property (p_half) else $error("serial half period short");
	a_sdi_hold: assert property (p_sdi_hold) else $error("input moved at sample");
	a_sdo_hold: assert property (p_sdo_hold) else $error("output moved clock high");
	a_frame_len: assert property (p_frame_len) else $error("frame not whole bytes");
	a_rdy_rise: assert property (p_rdy_rise) else $error("ready rose without read");
	c_read24: cover property ($rose(cs_n) && bit_cnt_reg == 6'h20);
	c_write: cover property ($rose(cs_n) && bit_cnt_reg == 6'h10);
	c_ready: cover property ($fell(rdy_n));
	c_shift: cover property (sdo_oe && $fell(sclk));
endmodule
`default_nettype wire

// ### verif/gyro_spi_register_bank_bench.sv
/* Bench joining the host and the register bank over one link.
   Assumes the host paces the serial clock and the checker watches the link. */
`timescale 1ns/100ps
`default_nettype none
module gyro_spi_register_bank_bench;
	logic        clk, rstn, wr, rd, irq, sync_level;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata;
	logic        rate_valid, temp_valid, conv_run, rate_enable, temp_enable, res_24;
	logic [23:0] rate_sample, temp_sample;
	int          n_mismatch = 0;
	int          checks_done = 0;
	logic [31:0] seed = 32'h48; // Fixed start value.
	// Config table: command, value read back at reset, byte written.
	logic [7:0] cfg_adr [6] = '{8'h01, 8'h28, 8'h2A, 8'h30, 8'h32, 8'h38};
	logic [7:0] cfg_rst [6] = '{8'h30, 8'h02, 8'h02, 8'h05, 8'h05, 8'h20};
	logic [7:0] cfg_val [6] = '{8'h38, 8'h0A, 8'h0A, 8'h05, 8'h05, 8'h22};
	gyro_spi_if link();
	gyro_spi_host u_gyro_spi_host (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .irq(irq), .spi(link), .sync_level(sync_level));
	gyro_spi_device #(.DATA_W(24)) u_gyro_spi_device (.clk(clk), .rstn(rstn), .spi(link),
		.rate_valid(rate_valid), .rate_sample(rate_sample), .temp_valid(temp_valid),
		.temp_sample(temp_sample), .conv_run(conv_run), .rate_enable(rate_enable),
		.temp_enable(temp_enable), .res_24(res_24));
	gyro_spi_properties u_gyro_spi_properties (.clk(clk), .rstn(rstn), .sclk(link.sclk),
		.cs_n(link.cs_n), .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe),
		.rdy_n(link.rdy_n));
	always #12.5 clk = ~clk;
	// Next random value.
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] v;
		v = s ^ (s << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction
	// Host control word: write byte, start, extra bytes, command.
	function automatic logic [31:0] ctrl_word(input logic [7:0] c, w, input logic [1:0] x);
		return {w, 8'h00, 2'b01, 4'h0, x, c};
	endfunction
	task automatic check(input string what, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic hw(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic hr(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// One whole frame; waits for idle, checks and clears the done event.
	task automatic xfer(input logic [7:0] c, w, input logic [1:0] x, output logic [31:0] d);
		logic [31:0] st;
		int n;
		hw(4'h0, ctrl_word(c, w, x));
		repeat (2) @(posedge clk);
		st = 32'h1;
		n = 0;
		while (st[0] !== 1'b0 && n < 1000) begin
			hr(4'h1, st);
			n++;
		end
		check("busy", st[0], 1'b0);
		check("irq set", irq, 1'b1);
		hw(4'h2, 32'h3);
		#1 check("irq clear", irq, 1'b0);
		hr(4'h4, d);
	endtask
	// Converter strobe on one channel, then let the flags settle.
	task automatic feed(input logic r, input logic [23:0] v);
		@(posedge clk);
		rate_sample <= v;
		temp_sample <= v;
		rate_valid <= r;
		temp_valid <= !r;
		@(posedge clk);
		rate_valid <= 1'b0;
		temp_valid <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	initial begin
		#1500000;
		n_mismatch++;
		end_of_test();
	end
	initial begin
		logic [31:0] d;
		logic [23:0] s;
		{clk, rstn, wr, rd, rate_valid, temp_valid, addr, wdata} = '0;
		{rate_sample, temp_sample} = '0;
		sync_level = 1'b1;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		hw(4'h3, 32'h1);
		hr(4'hF, d);
		check("unmapped", d, 32'h0);
		for (int i = 0; i < 6; i++) begin
			xfer(cfg_adr[i] | 8'h40, 8'h00, 2'h0, d);
			check("reset value", d[7:0], cfg_rst[i]);
		end
		xfer(8'h40, 8'h00, 2'h0, d);
		check("cmd read", d[7:0], 8'h00);
		xfer(8'h44, 8'h00, 2'h0, d);
		check("reserved read", d[7:0], 8'h00);
		// Fixed patterns and conversion times
		for (int i = 0; i < 6; i++) xfer(cfg_adr[i], cfg_val[i], 2'h0, d);
		check("enables", {rate_enable, temp_enable, res_24}, 3'h7);
		xfer(8'h41, 8'h00, 2'h0, d);
		check("io readback", d[7:0], 8'h38);
		for (int k = 0; k < 4; k++) begin
			seed = xs(seed);
			s = k[0] ? seed[31:8] : seed[23:0];
			feed(k[0], ~s);
			check("ready all", link.rdy_n, 1'b1);
			feed(!k[0], s);
			check("ready low", link.rdy_n, 1'b0);
			xfer(k[0] ? 8'h4A : 8'h48, 8'h00, 2'h2, d);
			check("sample", d[23:0], s);
			check("ready back", link.rdy_n, 1'b1);
		end
		xfer(8'h0A, 8'h5A, 2'h0, d);
		xfer(8'h4A, 8'h00, 2'h2, d);
		check("ro write", d[23:0], s);
		xfer(8'h01, 8'h31, 2'h0, d);
		@(posedge clk) sync_level <= 1'b0;
		repeat (4) @(posedge clk);
		#1 check("held", conv_run, 1'b0);
		feed(1'b1, seed[23:0]);
		check("no sample", link.rdy_n, 1'b1);
		@(posedge clk) sync_level <= 1'b1;
		repeat (4) @(posedge clk);
		#1 check("running", conv_run, 1'b1);
		feed(1'b0, seed[31:8]);
		check("ready any", link.rdy_n, 1'b0);
		hr(4'h1, d);
		check("status ready", d[1], 1'b1);
		hr(4'h2, d);
		check("ready event", d[1], 1'b1);
		xfer(8'h38, 8'h20, 2'h0, d);
		check("16 bit", res_24, 1'b0);
		xfer(8'h4A, 8'h00, 2'h1, d);
		check("data 16", d[15:0], seed[31:16]);
		check("ready 16", link.rdy_n, 1'b1);
		end_of_test();
	end
endmodule
`default_nettype wire
